// ---- hdl/bsm_defines.vh ----
`ifndef BSM_DEFINES_VH
`define BSM_DEFINES_VH
`define BSM_DATA_BYTES 13'h1100
`define BSM_CFG_BYTES 7'h41
`define BSM_SLA_BYTES 7'h40
`define BSM_CH0_BASE 4'hC
`define BSM_CH1_BASE 4'hD
`define BSM_OFS_CONTROL 4'h0
`define BSM_OFS_CHSTATUS 4'h1
`define BSM_OFS_INTMSK 4'h2
`define BSM_OFS_SLATAB 4'h3
`define BSM_OFS_CFGTAB 4'h4
`define BSM_OFS_DATA 4'h5
`define BSM_OFS_SELECT 4'h6
`define BSM_OFS_OFFSET 4'h7
`define BSM_ADDR_CTRL_STATUS 8'hF0
`define BSM_ADDR_CTRL_IRQ_MASK 8'hF1
`define BSM_CTL_START 0
`define BSM_CTL_CHRST 1
`define BSM_STS_OVF 0
`define BSM_STS_READY 1
`define BSM_MSK_OVF 0
`define BSM_CLK_HZ 100000000
`define BSM_OSC_HZ 12000000
`define BSM_PLL_HZ 156000000
`define BSM_SCL_HZ 1000000
`define BSM_QTR_CYCLES (`BSM_CLK_HZ / (4 * `BSM_SCL_HZ))
`define BSM_STARTUP_LOCK_US 1000
`define BSM_STARTUP_LOCK_CYCLES (`BSM_STARTUP_LOCK_US * (`BSM_CLK_HZ / 1000000))
`endif

// ---- hdl/bsm_fifo.v ----
`timescale 1ns/1ns
module bsm_fifo #(
  parameter W = 22,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_r;
  reg [AW:0] rp_r;
  wire [AW:0] used = wp_r - rp_r;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign in_ready_o = (used != DEPTH[AW:0]);
  assign out_valid_o = (used != {(AW+1){1'b0}});
  assign out_data_o = mem[rp_r[AW-1:0]];
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data_i;
    end
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// ---- hdl/bsm_seq_master.v ----
`timescale 1ns/1ns
`include "bsm_defines.vh"
module bsm_seq_master #(
  parameter LOCK_CYCLES = `BSM_STARTUP_LOCK_CYCLES
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] data_i,
  output wire [7:0] data_o,
  output wire data_oe_o,
  input wire frame_trigger_i,
  output wire irq_n_o,
  output wire irq_n_oe_o,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  output wire ready_o,
  output wire host_wait_o,
  output wire [1:0] ch_busy_o
);
  localparam E_IDLE = 3'd0;
  localparam E_LOAD = 3'd1;
  localparam E_START = 3'd2;
  localparam E_BIT = 3'd3;
  localparam E_STOP = 3'd4;
  localparam K_ADDR = 2'd0;
  localparam K_WR = 2'd1;
  localparam K_RD = 2'd2;
  localparam integer QTR_FULL = `BSM_QTR_CYCLES;
  localparam [4:0] QTR = QTR_FULL[4:0];

  function ch_of(input [7:0] a);
    ch_of = (a[7:4] == `BSM_CH1_BASE);
  endfunction
  function is_ch(input [7:0] a);
    is_ch = (a[7:4] == `BSM_CH0_BASE) || (a[7:4] == `BSM_CH1_BASE);
  endfunction
  function [13:0] lin(input c, input [12:0] p);
    lin = c ? ({1'b0, p} + {1'b0, `BSM_DATA_BYTES}) : {1'b0, p};
  endfunction
  function [7:0] tab(input c, input [6:0] p);
    tab = c ? ({1'b0, p} + {1'b0, `BSM_CFG_BYTES}) : {1'b0, p};
  endfunction

  reg [7:0] data_mem [0:8703];
  reg [7:0] cfg_mem [0:129];
  reg [7:0] sla_mem [0:127];
  reg [12:0] start_mem [0:129];

  // Three stages so that edge detection never reads the first flop
  reg [2:0] s1_r;
  reg [2:0] s2_r;
  reg [2:0] s3_r;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
      s3_r <= 3'h7;
    end else begin
      s1_r <= {cs_n_i, rd_n_i, wr_n_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire cs_act = ~s2_r[2];
  wire rd_act = cs_act & ~s2_r[1];
  wire wr_rise = s2_r[0] & ~s3_r[0] & ~s3_r[2];
  wire rd_rise = s2_r[1] & ~s3_r[1] & ~s3_r[2];

  reg [16:0] lock_cnt_r;
  reg ready_r;
  reg [7:0] ha_r;
  reg [7:0] hd_r;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      lock_cnt_r <= 17'h0_0000;
      ready_r <= 1'b0;
      ha_r <= 8'h00;
      hd_r <= 8'h00;
    end else begin
      if (lock_cnt_r == LOCK_CYCLES[16:0] - 17'h0_0001) begin
        ready_r <= 1'b1;
      end else begin
        lock_cnt_r <= lock_cnt_r + 17'h0_0001;
      end
      // Address is held through reads too, so the data pointer step sees the read's own address
      if (cs_act & (~s2_r[0] | ~s2_r[1])) begin
        ha_r <= addr_i;
      end
      if (cs_act & ~s2_r[0]) begin
        hd_r <= data_i;
      end
    end
  end

  wire hw = wr_rise & ready_r;
  wire hc = ch_of(ha_r);
  wire [3:0] hs = ha_r[3:0];
  wire hw_ch = hw & is_ch(ha_r);
  wire chrst = hw_ch & (hs == `BSM_OFS_CONTROL) & hd_r[`BSM_CTL_CHRST];
  wire start_req = hw_ch & (hs == `BSM_OFS_CONTROL) & hd_r[`BSM_CTL_START] & ~hd_r[`BSM_CTL_CHRST];

  reg [6:0] sla_ptr_r [0:1];
  reg [6:0] cfg_ptr_r [0:1];
  reg [12:0] dptr_r [0:1];
  reg [5:0] sel_r [0:1];
  reg [7:0] ofs_r [0:1];
  reg [7:0] intmsk_r [0:1];
  reg ovf_r;
  reg ovf_mask_r;
  reg [1:0] busy_r;
  reg [1:0] done_r;
  reg [1:0] nack_r;
  reg ovf_set;
  wire fifo_in_ready;
  wire fifo_valid;
  wire [21:0] fifo_out;
  wire push = hw_ch & (hs == `BSM_OFS_DATA) & (dptr_r[hc] < `BSM_DATA_BYTES) & ~busy_r[hc];
  wire [7:0] cidx = tab(hc, cfg_ptr_r[hc]);

  always @* begin
    ovf_set = 1'b0;
    if (hw_ch) begin
      case (hs)
        `BSM_OFS_SLATAB: ovf_set = (sla_ptr_r[hc] >= `BSM_SLA_BYTES);
        `BSM_OFS_CFGTAB: ovf_set = (cfg_ptr_r[hc] >= `BSM_CFG_BYTES);
        `BSM_OFS_DATA: ovf_set = (dptr_r[hc] >= `BSM_DATA_BYTES);
        default: ovf_set = 1'b0;
      endcase
    end
  end

  integer i;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 2; i = i + 1) begin
        sla_ptr_r[i] <= 7'h00;
        cfg_ptr_r[i] <= 7'h00;
        dptr_r[i] <= 13'h0000;
        sel_r[i] <= 6'h00;
        ofs_r[i] <= 8'h00;
        intmsk_r[i] <= 8'h00;
      end
      ovf_r <= 1'b0;
      ovf_mask_r <= 1'b0;
    end else begin
      // A new overflow wins over a channel reset in the same cycle
      ovf_r <= ovf_set | (ovf_r & ~chrst);
      if (hw & (ha_r == `BSM_ADDR_CTRL_IRQ_MASK)) begin
        ovf_mask_r <= hd_r[`BSM_MSK_OVF];
      end
      if (chrst) begin
        sla_ptr_r[hc] <= 7'h00;
        cfg_ptr_r[hc] <= 7'h00;
        dptr_r[hc] <= 13'h0000;
        sel_r[hc] <= 6'h00;
        ofs_r[hc] <= 8'h00;
      end else if (hw_ch & ~busy_r[hc]) begin
        case (hs)
          `BSM_OFS_INTMSK: intmsk_r[hc] <= hd_r;
          `BSM_OFS_SLATAB: begin
            if (sla_ptr_r[hc] < `BSM_SLA_BYTES) begin
              sla_mem[{hc, sla_ptr_r[hc][5:0]}] <= hd_r;
              sla_ptr_r[hc] <= sla_ptr_r[hc] + 7'h01;
            end
          end
          `BSM_OFS_CFGTAB: begin
            if (cfg_ptr_r[hc] < `BSM_CFG_BYTES) begin
              cfg_mem[cidx] <= hd_r;
              cfg_ptr_r[hc] <= cfg_ptr_r[hc] + 7'h01;
              // Running start address of each transaction's data block
              if (cfg_ptr_r[hc] == 7'h00) begin
                start_mem[cidx + 8'h01] <= 13'h0000;
              end else if (cfg_ptr_r[hc] < `BSM_SLA_BYTES) begin
                start_mem[cidx + 8'h01] <= start_mem[cidx] + {5'h00, hd_r};
              end
            end
          end
          `BSM_OFS_DATA: begin
            if (push & fifo_in_ready) begin
              dptr_r[hc] <= dptr_r[hc] + 13'h0001;
            end
          end
          `BSM_OFS_SELECT: begin
            sel_r[hc] <= hd_r[5:0];
            dptr_r[hc] <= start_mem[tab(hc, {1'b0, hd_r[5:0]} + 7'h01)] + {5'h00, ofs_r[hc]};
          end
          `BSM_OFS_OFFSET: begin
            ofs_r[hc] <= hd_r;
            dptr_r[hc] <= start_mem[tab(hc, {1'b0, sel_r[hc]} + 7'h01)] + {5'h00, hd_r};
          end
          default: ;
        endcase
      end
      if (rd_rise & is_ch(ha_r) & (ha_r[3:0] == `BSM_OFS_DATA) & (dptr_r[ch_of(ha_r)] < `BSM_DATA_BYTES)) begin
        dptr_r[ch_of(ha_r)] <= dptr_r[ch_of(ha_r)] + 13'h0001;
      end
    end
  end

  // Host words are queued so engine stores of read data never collide with them
  reg eng_we;
  reg [13:0] eng_wa;
  reg [7:0] eng_wd;
  bsm_fifo #(.W(22), .DEPTH(16), .AW(4)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push & ~chrst),
    .in_ready_o(fifo_in_ready),
    .in_data_i({lin(hc, dptr_r[hc]), hd_r}),
    .out_valid_o(fifo_valid),
    .out_ready_i(~eng_we),
    .out_data_o(fifo_out)
  );
  always @(posedge ref_clk_i) begin
    if (eng_we) begin
      data_mem[eng_wa] <= eng_wd;
    end else if (fifo_valid) begin
      data_mem[fifo_out[21:8]] <= fifo_out[7:0];
    end
  end

  // Host read path
  reg [7:0] rmux;
  wire rc = ch_of(addr_i);
  always @* begin
    rmux = 8'h00;
    if (is_ch(addr_i)) begin
      case (addr_i[3:0])
        `BSM_OFS_CHSTATUS: rmux = {5'h00, nack_r[rc], done_r[rc], busy_r[rc]};
        `BSM_OFS_INTMSK: rmux = intmsk_r[rc];
        `BSM_OFS_SLATAB: rmux = sla_mem[{rc, sla_ptr_r[rc][5:0]}];
        `BSM_OFS_CFGTAB: rmux = cfg_mem[tab(rc, cfg_ptr_r[rc])];
        `BSM_OFS_DATA: rmux = data_mem[lin(rc, dptr_r[rc])];
        `BSM_OFS_SELECT: rmux = {2'h0, sel_r[rc]};
        `BSM_OFS_OFFSET: rmux = ofs_r[rc];
        default: rmux = 8'h00;
      endcase
    end else if (addr_i == `BSM_ADDR_CTRL_STATUS) begin
      rmux = {6'h00, ready_r, ovf_r};
    end else if (addr_i == `BSM_ADDR_CTRL_IRQ_MASK) begin
      rmux = {7'h00, ovf_mask_r};
    end
  end
  reg [7:0] dout_r;
  reg dout_oe_r;
  reg irq_oe_r;
  reg wait_r;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      dout_r <= 8'h00;
      dout_oe_r <= 1'b0;
      irq_oe_r <= 1'b0;
      wait_r <= 1'b0;
    end else begin
      dout_oe_r <= rd_act;
      // Data is held once the read is under way so it stays stable
      if (rd_act & ~(s3_r[2] == 1'b0 && s3_r[1] == 1'b0)) begin
        dout_r <= rmux;
      end
      irq_oe_r <= ovf_r & ~ovf_mask_r;
      wait_r <= ~fifo_in_ready;
    end
  end

  // Serial engine; the quarter-bit divider runs even with the bus idle
  reg [4:0] div_r;
  wire qtick = (div_r == QTR - 5'h01);
  reg [2:0] st_r;
  reg [1:0] ph_r;
  reg [1:0] kind_r;
  reg [3:0] bit_r;
  reg [8:0] sh_r;
  reg [8:0] rx_r;
  reg ech_r;
  reg last_ch_r;
  reg armed_r;
  reg trigger_d_r;
  reg [6:0] tn_r;
  reg [6:0] total_r;
  reg [7:0] left_r;
  reg [12:0] eptr_r;
  reg erd_r;
  reg scl_oe_r;
  reg sda_oe_r;
  wire trigger_edge = frame_trigger_i & ~trigger_d_r;
  wire [7:0] tidx = tab(ech_r, tn_r + 7'h01);
  wire [7:0] next_wr = data_mem[lin(ech_r, eptr_r + 13'h0001)];

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      div_r <= 5'h00;
      st_r <= E_IDLE;
      ph_r <= 2'h0;
      kind_r <= K_ADDR;
      bit_r <= 4'h0;
      sh_r <= 9'h1FF;
      rx_r <= 9'h000;
      ech_r <= 1'b0;
      last_ch_r <= 1'b0;
      armed_r <= 1'b0;
      trigger_d_r <= 1'b0;
      tn_r <= 7'h00;
      total_r <= 7'h00;
      left_r <= 8'h00;
      eptr_r <= 13'h0000;
      erd_r <= 1'b0;
      busy_r <= 2'h0;
      done_r <= 2'h0;
      nack_r <= 2'h0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      eng_we <= 1'b0;
      eng_wa <= 14'h0000;
      eng_wd <= 8'h00;
    end else begin
      div_r <= qtick ? 5'h00 : div_r + 5'h01;
      trigger_d_r <= frame_trigger_i;
      eng_we <= 1'b0;
      if (chrst) begin
        busy_r[hc] <= 1'b0;
        done_r[hc] <= 1'b0;
        nack_r[hc] <= 1'b0;
        if (hc == ech_r) begin
          armed_r <= 1'b0;
        end
      end
      if (chrst & busy_r[hc] & (hc == ech_r)) begin
        // Abort releases both lines at once
        st_r <= E_IDLE;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (st_r)
          E_IDLE: begin
            if (start_req | (trigger_edge & armed_r)) begin
              ech_r <= start_req ? hc : last_ch_r;
              last_ch_r <= start_req ? hc : last_ch_r;
              armed_r <= 1'b1;
              tn_r <= 7'h00;
              total_r <= cfg_mem[tab(start_req ? hc : last_ch_r, 7'h00)][6:0];
              busy_r[start_req ? hc : last_ch_r] <= 1'b1;
              done_r[start_req ? hc : last_ch_r] <= 1'b0;
              nack_r[start_req ? hc : last_ch_r] <= 1'b0;
              st_r <= E_LOAD;
            end
          end
          E_LOAD: begin
            if (tn_r < total_r) begin
              sh_r <= {sla_mem[{ech_r, tn_r[5:0]}], 1'b1};
              erd_r <= sla_mem[{ech_r, tn_r[5:0]}][0];
              left_r <= cfg_mem[tidx];
              eptr_r <= start_mem[tidx];
              ph_r <= 2'h0;
              st_r <= E_START;
            end else begin
              busy_r[ech_r] <= 1'b0;
              done_r[ech_r] <= 1'b1;
              st_r <= E_IDLE;
            end
          end
          E_START, E_BIT, E_STOP: begin
            if (qtick) begin
              ph_r <= ph_r + 2'h1;
              case (ph_r)
                2'h0: sda_oe_r <= (st_r == E_START) ? 1'b0 : (st_r == E_STOP) ? 1'b1 : ~sh_r[8];
                2'h1: scl_oe_r <= 1'b0;
                2'h2: begin
                  // Slave holding the clock low stretches this phase
                  if (~scl_i) begin
                    ph_r <= ph_r;
                  end else if (st_r == E_START) begin
                    sda_oe_r <= 1'b1;
                  end else if (st_r == E_STOP) begin
                    sda_oe_r <= 1'b0;
                  end else begin
                    rx_r <= {rx_r[7:0], sda_i};
                  end
                end
                default: begin
                  if (st_r == E_STOP) begin
                    busy_r[ech_r] <= 1'b0;
                    done_r[ech_r] <= 1'b1;
                    st_r <= E_IDLE;
                  end else begin
                    scl_oe_r <= 1'b1;
                    bit_r <= (st_r == E_START || bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
                    // The start phase must not consume the first address bit
                    sh_r <= (st_r == E_START) ? sh_r : {sh_r[7:0], 1'b1};
                    if (st_r == E_START) begin
                      st_r <= E_BIT;
                      kind_r <= K_ADDR;
                    end else if (bit_r == 4'h8) begin
                      if ((kind_r != K_RD) & rx_r[0]) begin
                        nack_r[ech_r] <= 1'b1;
                        st_r <= E_STOP;
                      end else if (kind_r == K_ADDR & left_r == 8'h00) begin
                        tn_r <= tn_r + 7'h01;
                        st_r <= (tn_r + 7'h01 < total_r) ? E_LOAD : E_STOP;
                      end else if (kind_r == K_ADDR) begin
                        kind_r <= erd_r ? K_RD : K_WR;
                        sh_r <= erd_r ? {8'hFF, left_r == 8'h01} : {data_mem[lin(ech_r, eptr_r)], 1'b1};
                      end else begin
                        if (kind_r == K_RD) begin
                          eng_we <= 1'b1;
                          eng_wa <= lin(ech_r, eptr_r);
                          eng_wd <= rx_r[8:1];
                        end
                        left_r <= left_r - 8'h01;
                        eptr_r <= eptr_r + 13'h0001;
                        if (left_r == 8'h01) begin
                          tn_r <= tn_r + 7'h01;
                          st_r <= (tn_r + 7'h01 < total_r) ? E_LOAD : E_STOP;
                        end else begin
                          sh_r <= (kind_r == K_RD) ? {8'hFF, left_r == 8'h02} : {next_wr, 1'b1};
                        end
                      end
                    end
                  end
                end
              endcase
            end
          end
          default: st_r <= E_IDLE;
        endcase
      end
    end
  end

  assign data_o = dout_r;
  assign data_oe_o = dout_oe_r;
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = irq_oe_r;
  assign scl_o = 1'b0;
  assign scl_oe_o = scl_oe_r;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_r;
  assign ready_o = ready_r;
  assign host_wait_o = wait_r;
  assign ch_busy_o = busy_r;
endmodule

// ---- sim/bsm_seq_master_asserts.sv ----
`timescale 1ns/1ns
module bsm_seq_master_asserts #(
  parameter LOCK_CYCLES = 20
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire rd_n_i,
  input wire frame_trigger_i,
  input wire data_oe_o,
  input wire irq_n_o,
  input wire irq_n_oe_o,
  input wire scl_oe_o,
  input wire sda_oe_o,
  input wire ready_o,
  input wire [1:0] ch_busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  reg [31:0] lock_cnt_r;
  reg [3:0] cause_age_r;
  // Age of the last host access or trigger, so a channel start can be tied to a cause
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      lock_cnt_r <= 32'h0000_0000;
      cause_age_r <= 4'hf;
    end else begin
      if (lock_cnt_r != 32'hffff_ffff) begin
        lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
      end
      if (!cs_n_i || frame_trigger_i) begin
        cause_age_r <= 4'h0;
      end else if (cause_age_r != 4'hf) begin
        cause_age_r <= cause_age_r + 4'h1;
      end
    end
  end
  chk_ready_not_early: assert property (ready_o |-> lock_cnt_r >= LOCK_CYCLES - 2)
    else $error("ready before lock time");
  chk_ready_not_late: assert property (lock_cnt_r == LOCK_CYCLES + 3 |-> ready_o)
    else $error("ready late after reset");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !data_oe_o && !irq_n_oe_o && !scl_oe_o && !sda_oe_o
    && ch_busy_o == 2'b00 && !ready_o)
    else $error("outputs active right after reset");
  chk_read_drives: assert property ((!rd_n_i && !cs_n_i) [*5] |-> data_oe_o)
    else $error("read cycle not driving data");
  chk_read_cause: assert property ($rose(data_oe_o) |-> $past(!rd_n_i && !cs_n_i, 2))
    else $error("data driven without synced read");
  chk_deselect_float: assert property (cs_n_i [*5] |-> !data_oe_o)
    else $error("data driven while deselected");
  chk_irq_pin_low: assert property (irq_n_oe_o |-> !irq_n_o)
    else $error("interrupt pin not low when driven");
  chk_irq_cause: assert property ($rose(irq_n_oe_o) |-> $past(!cs_n_i, 2))
    else $error("interrupt without host write");
  chk_bus_only_busy: assert property (scl_oe_o || sda_oe_o |-> ch_busy_o != 2'b00)
    else $error("serial bus driven while idle");
  chk_start_cause: assert property ($rose(ch_busy_o[0]) || $rose(ch_busy_o[1]) |-> cause_age_r < 4'h8)
    else $error("channel started without cause");
  chk_trigger_frame: assert property ($rose(frame_trigger_i) && ch_busy_o == 2'b00 |-> ##[1:8] ch_busy_o != 2'b00)
    else $error("trigger did not start a frame");
endmodule

// ---- sim/bsm_slave_model.sv ----
`timescale 1ns/1ns
module bsm_slave_model #(
  parameter RD_BYTE = 8'hc3
) (
  input wire scl_i,
  input wire sda_i,
  output reg scl_oe_o,
  output reg sda_oe_o
);
  // Only addresses 50h and 51h are answered, every other address sees a NACK
  reg [7:0] log_r [0:15];
  reg [7:0] shift_r;
  reg first_r, addressed_r, is_read_r, stretch_r, last_mack_r;
  integer n_log, n_start, n_stop, bitcnt;
  function automatic logic rx_ph();
    return first_r || !is_read_r || !addressed_r;
  endfunction
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    first_r = 1'b1;
    addressed_r = 1'b0;
    is_read_r = 1'b0;
    stretch_r = 1'b0;
    last_mack_r = 1'b0;
    n_log = 0;
    n_start = 0;
    n_stop = 0;
    bitcnt = 0;
  end
  always @(negedge sda_i) begin
    if (scl_i) begin
      n_start = n_start + 1;
      bitcnt = 0;
      first_r = 1'b1;
      sda_oe_o = 1'b0;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i) begin
      n_stop = n_stop + 1;
      addressed_r = 1'b0;
    end
  end
  always @(posedge scl_i) begin
    if (bitcnt < 8) begin
      shift_r = {shift_r[6:0], sda_i};
    end else if (!rx_ph()) begin
      last_mack_r = sda_i;
    end
    bitcnt = bitcnt + 1;
  end
  always @(negedge scl_i) begin
    if (bitcnt == 8) begin
      if (first_r) begin
        addressed_r = shift_r[7:2] == 6'h28;
        is_read_r = shift_r[0];
      end
      if (rx_ph()) begin
        log_r[n_log] = shift_r;
        n_log = n_log + 1;
      end
      sda_oe_o = rx_ph() && addressed_r;
    end else if (bitcnt == 9) begin
      bitcnt = 0;
      first_r = 1'b0;
      sda_oe_o = !rx_ph() && !RD_BYTE[7];
      // A slow slave holds the clock low after each acknowledge
      if (stretch_r) begin
        scl_oe_o = 1'b1;
        scl_oe_o <= #1500 1'b0;
      end
    end else if (!rx_ph() && bitcnt > 0) begin
      sda_oe_o = !RD_BYTE[7 - bitcnt];
    end
  end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  localparam LOCK = 20;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cs_n = 1'b1;
  reg rd_n = 1'b1;
  reg wr_n = 1'b1;
  reg frame_trigger = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  wire [7:0] rdata;
  wire [1:0] busy;
  wire oe, irq_oe, scl_oe, sda_oe, s_scl_oe, s_sda_oe, ready;
  wire scl = !(scl_oe || s_scl_oe);
  wire sda = !(sda_oe || s_sda_oe);
  integer errors = 0;
  integer n_checks = 0;
  integer s0, p0, k;
  always #5 clk = !clk;
  bsm_seq_master #(.LOCK_CYCLES(LOCK)) u_dut (.ref_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_o(oe), .frame_trigger_i(frame_trigger),
    .irq_n_o(), .irq_n_oe_o(irq_oe), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .ready_o(ready), .host_wait_o(), .ch_busy_o(busy));
  bsm_slave_model u_slave (.scl_i(scl), .sda_i(sda), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (errors == 0 && n_checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task bus_wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      addr <= a;
      wdata <= d;
      tick(4);
      wr_n <= 1'b1;
      // Select stays low past the synced rising strobe so the write is taken
      tick(5);
      cs_n <= 1'b1;
      tick(4);
    end
  endtask
  task bus_rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      addr <= a;
      tick(5);
      #1 check(oe, 1'b1);
      check(rdata, exp);
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      tick(5);
      #1 check(oe, 1'b0);
    end
  endtask
  task wait_ready;
    begin
      #1;
      for (k = 0; k < 20 && ready !== 1'b1; k = k + 1) begin
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= 8'hf0;
        tick(5);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        tick(5);
        #1;
      end
      if (ready !== 1'b1) begin
        errors = errors + 1;
        tally_and_finish;
      end
    end
  endtask
  task wait_idle;
    begin
      #1;
      for (k = 0; k < 30000 && busy !== 2'b00; k = k + 1) begin
        @(posedge clk) #1;
      end
      if (busy !== 2'b00) begin
        errors = errors + 1;
        tally_and_finish;
      end
    end
  endtask
  task do_reset;
    begin
      @(posedge clk);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      wait_ready;
    end
  endtask
  task load(input [7:0] a0, input [7:0] a1, input [7:0] d0, input [7:0] d1);
    begin
      bus_wr(8'hc0, 8'h02);
      bus_wr(8'hc4, 8'h02);
      bus_wr(8'hc4, 8'h01);
      bus_wr(8'hc4, 8'h01);
      bus_wr(8'hc3, a0);
      bus_wr(8'hc3, a1);
      bus_wr(8'hc6, 8'h00);
      bus_wr(8'hc7, 8'h00);
      bus_wr(8'hc5, d0);
      bus_wr(8'hc5, d1);
      #1 check(busy, 2'b00);
      s0 = u_slave.n_start;
      p0 = u_slave.n_stop;
      bus_wr(8'hc0, 8'h01);
      #1 check(busy, 2'b01);
    end
  endtask
  task s_select;
    begin
      bus_rd(8'hc6, 8'h00);
      bus_rd(8'hc7, 8'h00);
      bus_rd(8'hf0, 8'h02);
      bus_wr(8'hc6, 8'h01);
      bus_wr(8'hc7, 8'h02);
      bus_rd(8'hc6, 8'h01);
      bus_rd(8'hc7, 8'h02);
      @(posedge clk);
      rd_n <= 1'b0;
      tick(6);
      #1 check(oe, 1'b0);
      @(posedge clk);
      rd_n <= 1'b1;
      do_reset;
      bus_rd(8'hc6, 8'h00);
      bus_rd(8'hc7, 8'h00);
    end
  endtask
  task s_sequence;
    begin
      load(8'ha0, 8'ha3, 8'h5a, 8'hff);
      wait_idle;
      check(u_slave.n_start - s0, 8'h02);
      check(u_slave.n_stop - p0, 8'h01);
      check(u_slave.log_r[0], 8'ha0);
      check(u_slave.log_r[1], 8'h5a);
      check(u_slave.log_r[2], 8'ha3);
      check(u_slave.last_mack_r, 1'b1);
      bus_wr(8'hc6, 8'h01);
      bus_wr(8'hc7, 8'h00);
      bus_rd(8'hc1, 8'h02);
      bus_rd(8'hc5, 8'hc3);
      u_slave.stretch_r = 1'b1;
      s0 = u_slave.n_start;
      @(posedge clk);
      frame_trigger <= 1'b1;
      tick(2);
      frame_trigger <= 1'b0;
      tick(4);
      #1 check(busy, 2'b01);
      bus_wr(8'hd6, 8'h02);
      bus_rd(8'hd6, 8'h02);
      wait_idle;
      check(u_slave.n_start - s0, 8'h02);
      check(u_slave.log_r[5], 8'ha3);
      u_slave.stretch_r = 1'b0;
    end
  endtask
  task s_nack;
    begin
      load(8'ha5, 8'ha0, 8'hff, 8'h5a);
      wait_idle;
      check(u_slave.n_start - s0, 8'h01);
      check(u_slave.n_stop - p0, 8'h01);
      bus_wr(8'hc6, 8'h00);
      bus_wr(8'hc7, 8'h00);
      bus_rd(8'hc5, 8'hff);
    end
  endtask
  task s_overflow;
    begin
      bus_wr(8'hc0, 8'h02);
      for (k = 0; k < 64; k = k + 1) begin
        bus_wr(8'hc3, k[7:0]);
      end
      #1 check(irq_oe, 1'b0);
      bus_wr(8'hc3, 8'h00);
      #1 check(irq_oe, 1'b1);
      bus_rd(8'hf0, 8'h03);
      bus_wr(8'hf1, 8'h01);
      #1 check(irq_oe, 1'b0);
      bus_wr(8'hf1, 8'h00);
      #1 check(irq_oe, 1'b1);
      bus_wr(8'hc0, 8'h02);
      bus_rd(8'hf0, 8'h02);
    end
  endtask
  initial begin
    tick(2);
    rst <= 1'b0;
    wait_ready;
    s_select;
    s_sequence;
    s_nack;
    s_overflow;
    // Reset in mid-frame comes last: the slave may be left holding the data line
    load(8'ha0, 8'ha3, 8'h5a, 8'hff);
    tick(300);
    do_reset;
    check(busy, 2'b00);
    bus_rd(8'hc6, 8'h00);
    tally_and_finish;
  end
endmodule
bind bsm_seq_master bsm_seq_master_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.ref_clk_i, .rst_i, .cs_n_i,
  .rd_n_i, .frame_trigger_i, .data_oe_o, .irq_n_o, .irq_n_oe_o, .scl_oe_o, .sda_oe_o, .ready_o, .ch_busy_o);
